/* File: src/serial_port_ctrl.sv */
// Summary of operation
// R1: Loopback forces enabled outputs to constant one
// R2: Gate high makes enable latch transparent
// R3: Enable bit high activates output, low powers down
// R4: Both outputs off powers down channel transmit logic
// R5: Gate falling edge holds captured enable bits
// R6: Reset clears the enable latch
// R7: Odd bits second output, even bits first/receive
// R8: Partner tolerates 200 us settling after re-enable
// R9: Bit clock is reference times 10 or 20
// R10: Partner avoids half rate with input clock select
// R11: Speed select picks one of three rate ranges
// R12: Partner matches reference frequency to range
// R13: Line select routes one input to recovery
// R14: Loopback routes transmit data into recovery
// R15: Link fault valid only when four conditions hold
// R16: Amplitude select sets 140/280/420 mV trip
// R17: Amplitude monitor sees selected input only
// R18: Loopback disables amplitude monitor
// R19: Sixty quiet bits fault, three good chars clear; code faults only on the seventh quiet char (seventy bits)
// R20: Disabled receive channel shows link fault
// R21: Three-level selects decoded and re-sampled
// R22: Enable latch loads while gate high, resets zero
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module serial_port_ctrl
	import serial_port_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Static three-level selects as comparator pairs
	input  wire logic        speedRangeHigh,
	input  wire logic        speedRangeLow,
	input  wire logic        ampThresholdHigh,
	input  wire logic        ampThresholdLow,
	// Per-channel line selects and serial data
	input  wire logic [3:0]  lineInputSelect,
	input  wire logic [3:0]  lineInputPrimary,
	input  wire logic [3:0]  lineInputSecondary,
	input  wire logic [3:0]  txSerialData,
	input  wire logic [3:0]  freqInRange,
	input  wire logic [15:0] ampPrimaryMv,
	input  wire logic [15:0] ampSecondaryMv,
	input  wire logic        charStrobe,
	// Outputs
	output logic [7:0]       serialOutPair,
	output logic [7:0]       serialOutEnable,
	output logic [3:0]       txLogicPowered,
	output logic [3:0]       recoveryData,
	output logic [3:0]       linkFault_n,
	output logic [4:0]       clockMultiplier,
	output logic [1:0]       rateRange,
	output logic [11:0]      ampTripMv
);

	// ---------------------------------------------------------------
	// Software control state
	// ---------------------------------------------------------------
	logic       loopbackEnable;
	logic       halfRateRefSelect;
	logic       driverEnableLatchGate;
	logic       rxEnableLatchGate;
	logic [7:0] sharedEnableBus;
	logic [7:0] outEnableLatch;
	logic [3:0] rxEnableLatch;
	level_t     speedLevel;
	level_t     ampLevel;
	logic [3:0] densityOk;
	logic [3:0] prevSel;
	logic [3:0] charEdge;
	logic       wbReq;

	assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Byte lane 0 write helper
	function automatic logic [7:0] laneWrite(input logic [7:0] old,
	                                         input logic [31:0] din,
	                                         input logic [3:0] sel);
		laneWrite = sel[0] ? din[7:0] : old;
	endfunction : laneWrite

	// ---------------------------------------------------------------
	// Bus acknowledge: one cycle after request, dropped next cycle
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			wb_ack_o <= 1'b0;
		else if (clkEn)
			wb_ack_o <= wbReq;
	end

	// Control register writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			loopbackEnable        <= 1'b0;
			halfRateRefSelect     <= 1'b0;
			driverEnableLatchGate <= 1'b0;
			rxEnableLatchGate     <= 1'b0;
			sharedEnableBus       <= `ENABLE_RESET;
		end else if (clkEn && wbReq && wb_we_i) begin
			if (wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
				loopbackEnable        <= wb_dat_i[`CTRL_LOOPBACK];
				halfRateRefSelect     <= wb_dat_i[`CTRL_HALFRATE];
				driverEnableLatchGate <= wb_dat_i[`CTRL_DRVGATE];
				rxEnableLatchGate     <= wb_dat_i[`CTRL_RXGATE];
			end
			if (wb_adr_i == `REG_ENABLE)
				sharedEnableBus <= laneWrite(sharedEnableBus, wb_dat_i, wb_sel_i);
		end
	end

	// Read mux; unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0;
		end else if (clkEn) begin
			case (wb_adr_i)
				`REG_CTRL:   wb_dat_o <= {28'h0, rxEnableLatchGate, driverEnableLatchGate,
				                          halfRateRefSelect, loopbackEnable};
				`REG_ENABLE: wb_dat_o <= {24'h0, sharedEnableBus};
				`REG_STATUS: wb_dat_o <= {16'h0, rxEnableLatch, linkFault_n, outEnableLatch};
				`REG_RATE:   wb_dat_o <= {25'h0, rateRange, clockMultiplier};
				`REG_AMP:    wb_dat_o <= {20'h0, ampTripMv};
				default:     wb_dat_o <= 32'h0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Enable latches: transparent while gate high, hold when low
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			outEnableLatch <= `ENABLE_RESET; // see R6
		else if (clkEn && driverEnableLatchGate)
			outEnableLatch <= sharedEnableBus; // see R2 see R5 see R22
	end

	// Receive enable uses only even bits
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rxEnableLatch <= 4'h0;
		else if (clkEn && rxEnableLatchGate)
			rxEnableLatch <= {sharedEnableBus[6], sharedEnableBus[4],
			                  sharedEnableBus[2], sharedEnableBus[0]}; // see R7
	end

	// ---------------------------------------------------------------
	// Static select decoding
	// ---------------------------------------------------------------
	level_decode speedDecode (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clkEn   (clkEn),
		.pinHigh (speedRangeHigh),
		.pinLow  (speedRangeLow),
		.level   (speedLevel)
	);

	level_decode ampDecode (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clkEn   (clkEn),
		.pinHigh (ampThresholdHigh),
		.pinLow  (ampThresholdLow),
		.level   (ampLevel)
	);

	// Rate range, multiplier and amplitude trip
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rateRange       <= RANGE_400_800;
			clockMultiplier <= `MULT_FULL;
			ampTripMv       <= `AMP_MID_MV;
		end else if (clkEn) begin
			clockMultiplier <= halfRateRefSelect ? `MULT_HALF : `MULT_FULL; // see R9
			case (speedLevel)
				LVL_LOW:  rateRange <= RANGE_195_400; // see R11
				LVL_HIGH: rateRange <= RANGE_800_1500;
				default:  rateRange <= RANGE_400_800;
			endcase
			case (ampLevel)
				LVL_LOW:  ampTripMv <= `AMP_LOW_MV; // see R16
				LVL_HIGH: ampTripMv <= `AMP_HIGH_MV;
				default:  ampTripMv <= `AMP_MID_MV;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Per-channel transmit, recovery and link fault
	// ---------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : gChan
			logic selData;
			logic ampOk;
			logic chEdge;

			assign selData = lineInputSelect[ch] ? lineInputSecondary[ch]
			                                     : lineInputPrimary[ch]; // see R13
			// Amplitude code in 35 mV steps, taken from the selected input only
			assign ampOk = (12'(lineInputSelect[ch] ? ampSecondaryMv[4*ch+:4]
			                                        : ampPrimaryMv[4*ch+:4]) * `AMP_STEP_MV
			               >= ampTripMv); // see R17

			// Drivers: loopback forces one, disabled drives zero
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					serialOutPair[2*ch+1:2*ch]   <= 2'b00;
					serialOutEnable[2*ch+1:2*ch] <= 2'b00;
					txLogicPowered[ch]           <= 1'b0;
				end else if (clkEn) begin
					serialOutEnable[2*ch+1:2*ch] <= outEnableLatch[2*ch+1:2*ch]; // see R3 see R7
					txLogicPowered[ch] <= |outEnableLatch[2*ch+1:2*ch]; // see R4
					serialOutPair[2*ch+1:2*ch] <= outEnableLatch[2*ch+1:2*ch] &
						(loopbackEnable ? 2'b11 : {2{txSerialData[ch]}}); // see R1
				end
			end

			// Recovery input: loopback replaces line data
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					recoveryData[ch] <= 1'b0;
					prevSel[ch]      <= 1'b0;
					charEdge[ch]     <= 1'b0;
				end else if (clkEn) begin
					recoveryData[ch] <= loopbackEnable ? txSerialData[ch] : selData; // see R14
					prevSel[ch] <= recoveryData[ch];
					if (charStrobe)
						charEdge[ch] <= 1'b0;
					else if (recoveryData[ch] != prevSel[ch])
						charEdge[ch] <= 1'b1;
				end
			end

			assign chEdge = charEdge[ch] | (recoveryData[ch] != prevSel[ch]);

			transition_monitor density (
				.ref_clk     (ref_clk),
				.nrst        (nrst),
				.clkEn       (clkEn),
				.charStrobe  (charStrobe),
				.charHasEdge (chEdge),
				.densityOk   (densityOk[ch])
			);

			// Fault indicator combines all conditions
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst)
					linkFault_n[ch] <= 1'b0;
				else if (clkEn)
					linkFault_n[ch] <= rxEnableLatch[ch] & densityOk[ch] & freqInRange[ch] &
						(loopbackEnable | ampOk); // see R15 see R18 see R20
			end
		end
	endgenerate

endmodule : serial_port_ctrl

/* File: inc/serial_port_consts.svh */
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_ENABLE      8'h04
`define REG_STATUS      8'h08
`define REG_RATE        8'h0C
`define REG_AMP         8'h10

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CTRL_LOOPBACK   0
`define CTRL_HALFRATE   1
`define CTRL_DRVGATE    2
`define CTRL_RXGATE     3
`define CTRL_RESET      8'h00
`define ENABLE_RESET    8'h00

// ---------------------------------------------------------------
// Multipliers, timing and amplitude trip levels
// ---------------------------------------------------------------
`define MULT_FULL       5'd10
`define MULT_HALF       5'd20
`define NOTRANS_BITS    60
`define CHAR_BITS       10
`define NOTRANS_CHARS   (`NOTRANS_BITS / `CHAR_BITS)
`define GOOD_CHARS      3
`define AMP_LOW_MV      12'd140
`define AMP_MID_MV      12'd280
`define AMP_HIGH_MV     12'd420
`define AMP_STEP_MV     12'd35

`endif

/* File: inc/serial_port_pkg.sv */
package serial_port_pkg;

	// Three-level static select code
	typedef enum logic [1:0] {
		LVL_LOW  = 2'b00,
		LVL_MID  = 2'b01,
		LVL_HIGH = 2'b10
	} level_t;

	// Serial rate range
	typedef enum logic [1:0] {
		RANGE_195_400  = 2'b00,
		RANGE_400_800  = 2'b01,
		RANGE_800_1500 = 2'b10
	} range_t;

endpackage : serial_port_pkg

/* File: src/level_decode.sv */
`timescale 1ns/1ps
`include "serial_port_consts.svh"

// Three-level pin: decoded from a high and a low comparator, 3-flop filtered
module level_decode
	import serial_port_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic clkEn,
	input  wire logic pinHigh,
	input  wire logic pinLow,
	output level_t    level
);

	logic [2:0] syncHigh;
	logic [2:0] syncLow;

	// Three-stage synchroniser per comparator
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			syncHigh <= 3'h0;
			syncLow  <= 3'h0;
		end else if (clkEn) begin
			syncHigh <= {syncHigh[1:0], pinHigh};
			syncLow  <= {syncLow[1:0], pinLow};
		end
	end

	// Accept change once stages two and three agree
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			level <= LVL_MID;
		end else if (clkEn && syncHigh[2] == syncHigh[1] && syncLow[2] == syncLow[1]) begin
			if (syncHigh[2])
				level <= LVL_HIGH; // see R21
			else if (syncLow[2])
				level <= LVL_LOW;
			else
				level <= LVL_MID;
		end
	end

endmodule : level_decode

/* File: src/transition_monitor.sv */
`timescale 1ns/1ps
`include "serial_port_consts.svh"

// Per-channel transition density tracker, counted per character
module transition_monitor (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic clkEn,
	input  wire logic charStrobe,
	input  wire logic charHasEdge,
	output logic      densityOk
);

	logic [3:0] quietChars;
	logic [1:0] goodChars;

	// Quiet-run and good-run counters over whole characters
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			quietChars <= 4'h0;
			goodChars  <= 2'h0;
			densityOk  <= 1'b0;
		end else if (clkEn && charStrobe) begin
			if (charHasEdge) begin
				quietChars <= 4'h0;
				if (goodChars != 2'(`GOOD_CHARS))
					goodChars <= goodChars + 2'h1;
				if (goodChars == 2'(`GOOD_CHARS - 1))
					densityOk <= 1'b1; // see R19
			end else begin
				goodChars <= 2'h0;
				if (quietChars != 4'hF)
					quietChars <= quietChars + 4'h1;
				if (quietChars >= 4'(`NOTRANS_CHARS))
					densityOk <= 1'b0; // see R19
			end
		end
	end

endmodule : transition_monitor

/* File: tb/serial_port_ctrl_checker.sv */
`timescale 1ns/1ps
module serial_port_ctrl_checker (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [3:0]  lineInputSelect,
	input wire logic [3:0]  lineInputPrimary,
	input wire logic [3:0]  lineInputSecondary,
	input wire logic [3:0]  txSerialData,
	input wire logic [3:0]  freqInRange,
	input wire logic [7:0]  serialOutPair,
	input wire logic [7:0]  serialOutEnable,
	input wire logic [3:0]  txLogicPowered,
	input wire logic [3:0]  recoveryData,
	input wire logic [3:0]  linkFault_n,
	input wire logic [4:0]  clockMultiplier,
	input wire logic [1:0]  rateRange,
	input wire logic [11:0] ampTripMv
);
	logic       loop;
	logic       half;
	logic [3:0] route;
	logic [3:0] txOn;
	// Shadow of the control bits, taken at the acknowledged write
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			loop <= 1'b0;
			half <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00) begin
			loop <= wb_dat_i[0];
			half <= wb_dat_i[1];
		end
	end
	// Expected line route and per-channel transmit power
	assign route = (lineInputSelect & lineInputSecondary) | (~lineInputSelect & lineInputPrimary);
	assign txOn = {|serialOutEnable[7:6], |serialOutEnable[5:4],
		|serialOutEnable[3:2], |serialOutEnable[1:0]};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_reset_clears: assert property ($rose(nrst) |-> serialOutEnable == 8'h00)
		else $error("enables not clear after reset");
	a_loop_one: assert property ((loop && $stable(serialOutEnable)) [*4]
		|-> (serialOutPair & serialOutEnable) == serialOutEnable) else $error("loop output");
	a_tx_power: assert property ($stable(serialOutEnable) [*3] |-> txLogicPowered == txOn)
		else $error("tx power");
	a_mult_rate: assert property ($stable(half) [*3]
		|-> clockMultiplier == (half ? 5'd20 : 5'd10)) else $error("multiplier");
	a_levels_legal: assert property (rateRange != 2'b11 && (ampTripMv == 12'd140
		|| ampTripMv == 12'd280 || ampTripMv == 12'd420)) else $error("level decode");
	a_line_route: assert property ((!loop && $stable(route)) [*3] |-> recoveryData == route)
		else $error("line route");
	a_loop_route: assert property ((loop && $stable(txSerialData)) [*3]
		|-> recoveryData == txSerialData) else $error("loop route");
	a_freq_fault: assert property ((freqInRange == 4'h0) [*4] |-> linkFault_n == 4'h0)
		else $error("freq fault");
	cover property (loop && serialOutPair == 8'hFF);
	cover property ($fell(linkFault_n[0]));
	cover property (clockMultiplier == 5'd20);
endmodule : serial_port_ctrl_checker

bind serial_port_ctrl serial_port_ctrl_checker chk (
	.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.lineInputSelect(lineInputSelect), .lineInputPrimary(lineInputPrimary),
	.lineInputSecondary(lineInputSecondary), .txSerialData(txSerialData),
	.freqInRange(freqInRange), .serialOutPair(serialOutPair),
	.serialOutEnable(serialOutEnable), .txLogicPowered(txLogicPowered),
	.recoveryData(recoveryData), .linkFault_n(linkFault_n),
	.clockMultiplier(clockMultiplier), .rateRange(rateRange), .ampTripMv(ampTripMv)
);

/* File: tb/link_partner.sv */
`timescale 1ns/1ps
module link_partner
	import serial_port_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic [3:0] quiet,
	input  level_t          speedLevel,
	input  level_t          ampLevel,
	output logic            speedRangeHigh,
	output logic            speedRangeLow,
	output logic            ampThresholdHigh,
	output logic            ampThresholdLow,
	output logic [3:0]      lineInputPrimary,
	output logic [3:0]      lineInputSecondary,
	output logic            charStrobe
);
	logic [3:0] count;
	// Board logic judges levels only, never driver settle after re-enable
	// Comparator pairs; half rate is only used at the high range
	assign speedRangeHigh = speedLevel == LVL_HIGH;
	assign speedRangeLow = speedLevel == LVL_LOW;
	assign ampThresholdHigh = ampLevel == LVL_HIGH;
	assign ampThresholdLow = ampLevel == LVL_LOW;
	assign charStrobe = count == 4'h9;
	// One edge per character on each line unless held quiet
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count <= 4'h0;
			lineInputPrimary <= 4'h0;
			lineInputSecondary <= 4'h0;
		end else begin
			count <= (count == 4'h9) ? 4'h0 : count + 4'h1;
			if (count == 4'h0) lineInputPrimary <= lineInputPrimary ^ ~quiet;
			if (count == 4'h5) lineInputSecondary <= lineInputSecondary ^ ~quiet;
		end
	end
endmodule : link_partner

/* File: tb/serial_port_ctrl_bench.sv */
`timescale 1ns/1ps
module serial_port_ctrl_bench
	import serial_port_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        req = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rbus;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  lineSel = 4'h5;
	logic [3:0]  freq = 4'hF;
	logic [3:0]  quiet = 4'h0;
	logic [15:0] ampPri = 16'hFFFF;
	logic [15:0] ampSec = 16'hFFFF;
	level_t      speedLevel = LVL_MID;
	level_t      ampLevel = LVL_MID;
	logic        spH, spL, amH, amL, strobe;
	logic [3:0]  prim, sec, txPow, recov, fault;
	logic [7:0]  pair, oe;
	logic [4:0]  mult;
	logic [1:0]  rng;
	logic [11:0] trip;
	int          mismatches = 0;
	int          checked = 0;
	int          cycles = 0;
	level_t      lv[3] = '{LVL_LOW, LVL_MID, LVL_HIGH};
	logic [31:0] rateExp[3] = '{32'h0A, 32'h2A, 32'h4A};
	logic [31:0] ampExp[3] = '{32'h8C, 32'h118, 32'h1A4};

	always #5 ref_clk = ~ref_clk;

	serial_port_ctrl dut (
		.ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rbus),
		.wb_ack_o(ack), .speedRangeHigh(spH), .speedRangeLow(spL), .ampThresholdHigh(amH),
		.ampThresholdLow(amL), .lineInputSelect(lineSel), .lineInputPrimary(prim),
		.lineInputSecondary(sec), .txSerialData(prim), .freqInRange(freq),
		.ampPrimaryMv(ampPri), .ampSecondaryMv(ampSec), .charStrobe(strobe),
		.serialOutPair(pair), .serialOutEnable(oe), .txLogicPowered(txPow),
		.recoveryData(recov), .linkFault_n(fault), .clockMultiplier(mult),
		.rateRange(rng), .ampTripMv(trip)
	);

	link_partner peer (
		.ref_clk(ref_clk), .nrst(nrst), .quiet(quiet), .speedLevel(speedLevel),
		.ampLevel(ampLevel), .speedRangeHigh(spH), .speedRangeLow(spL),
		.ampThresholdHigh(amH), .ampThresholdLow(amL), .lineInputPrimary(prim),
		.lineInputSecondary(sec), .charStrobe(strobe)
	);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic report_and_stop;
		if (mismatches == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge ref_clk); while (ack !== 1'b1);
		rdat = rbus;
		req <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(1'b0, a, 32'h0);
		check(name, exp, rdat);
	endtask : rd

	// Cycle ceiling against a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h00, 32'h0, "ctrl");
		rd(8'h08, 32'h0, "status");
		bus(1'b1, 8'h14, 32'hFF);
		rd(8'h14, 32'h0, "unmapped");
		bus(1'b1, 8'h04, 32'h0C);
		bus(1'b1, 8'h00, 32'h04);
		rd(8'h08, 32'h000C, "open");
		check("oe", 32'h0C, 32'(oe));
		check("txpow", 32'h2, 32'(txPow));
		bus(1'b1, 8'h00, 32'h00);
		bus(1'b1, 8'h04, 32'hF3);
		rd(8'h08, 32'h000C, "hold");
		bus(1'b1, 8'h00, 32'h04);
		rd(8'h08, 32'h00F3, "reopen");
		check("txpow", 32'hD, 32'(txPow));
		for (int i = 0; i < 3; i++) begin
			speedLevel <= lv[i];
			ampLevel <= lv[i];
			repeat (12) @(posedge ref_clk);
			rd(8'h0C, rateExp[i], "rate");
			rd(8'h10, ampExp[i], "amp");
		end
		bus(1'b1, 8'h00, 32'h06);
		rd(8'h0C, 32'h54, "half");
		bus(1'b1, 8'h04, 32'hFF);
		bus(1'b1, 8'h00, 32'h0D);
		repeat (60) @(posedge ref_clk);
		check("pair", 32'hFF, 32'(pair));
		rd(8'h08, 32'hFFFF, "loop");
		quiet <= 4'hF;
		repeat (100) @(posedge ref_clk);
		rd(8'h08, 32'hF0FF, "quiet");
		quiet <= 4'h0;
		repeat (60) @(posedge ref_clk);
		rd(8'h08, 32'hFFFF, "resume");
		freq <= 4'h0;
		repeat (8) @(posedge ref_clk);
		rd(8'h08, 32'hF0FF, "freq");
		freq <= 4'hF;
		bus(1'b1, 8'h00, 32'h0C);
		ampPri <= 16'h0000;
		repeat (4) @(posedge ref_clk);
		rd(8'h08, 32'hF5FF, "ampsel");
		ampPri <= 16'hCCCC;
		ampSec <= 16'hBBBB;
		repeat (4) @(posedge ref_clk);
		rd(8'h08, 32'hFAFF, "amptrip");
		bus(1'b1, 8'h00, 32'h0D);
		repeat (4) @(posedge ref_clk);
		rd(8'h08, 32'hFFFF, "loopamp");
		bus(1'b1, 8'h04, 32'hAA);
		rd(8'h08, 32'h00AA, "rxoff");
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h08, 32'h0, "reset");
		lineSel <= 4'hA;
		repeat (20) @(posedge ref_clk);
		report_and_stop();
	end
endmodule : serial_port_ctrl_bench
